// ---- inc/ebsu_pkg.sv ----
`default_nettype none
package ebsu_pkg;
    // ********************************************************************
    // Bus pin values.
    // ********************************************************************
    localparam logic [3:0]  STATUS_AT_RESET = 4'h5;
    localparam logic [3:0]  STATUS_IDLE     = 4'hF;
    localparam logic [3:0]  STATUS_MEM      = 4'h8;
    localparam logic [3:0]  STATUS_IO       = 4'h9;
    localparam logic [3:0]  STATUS_FETCH    = 4'hA;
    localparam int          DED_ADDR_LO     = 2;
    localparam int          DED_ADDR_HI     = 27;
    localparam int          DED_ADDR_BITS   = 26;
    localparam int          HALF_BEATS      = 2;
    localparam int          BURST32_BEATS   = 4;
    localparam int          BURST16_BEATS   = 8;
    localparam logic [3:0]  ADDR_TOP_UNCACHED = 4'h4;
    localparam logic [3:0]  ADDR_TOP_CS0_UNC  = 4'h7;
    localparam logic [1:0]  ADDR_TOP_IO_INT   = 2'h3;
    localparam logic [31:0] IRAM_BASE       = 32'hFFFF_E000;
    localparam logic [31:0] DRAM_BASE       = 32'hFFFF_F000;
    localparam logic [31:0] IRAM_MASK       = 32'hFFFF_F000;
    localparam logic [6:0]  CS0_SMALL_TOP   = 7'h3F;

    // ********************************************************************
    // Types.
    // ********************************************************************
    typedef enum logic [1:0] {
        EBSU_BYTE,
        EBSU_HALF,
        EBSU_WORD,
        EBSU_BURST
    } ebsu_size_t;

    typedef enum logic [1:0] {
        EBSU_MEM_DATA,
        EBSU_MEM_FETCH,
        EBSU_IO
    } ebsu_space_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        ebsu_size_t  size;
        ebsu_space_t space;
        logic [31:0] wdata;
    } ebsu_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        internal;
        logic        cachable;
        logic        fault;
    } ebsu_rsp_t;
endpackage : ebsu_pkg
`default_nettype wire

// ---- verilog/ebsu_lanes.sv ----
`default_nettype none
module ebsu_lanes
    import ebsu_pkg::*;
(
    input  wire logic       half_mode,
    input  wire ebsu_size_t size,
    input  wire logic [1:0] addr_lo,
    input  wire logic       second_half,
    output logic      [3:0] lane_enable_n
);
    // ********************************************************************
    // Lane enable decode; in half mode bits 3:2 carry address bit 1 and
    // the byte-or-half flag.
    // ********************************************************************
    always_comb begin
        lane_enable_n = 4'h0;
        if (!half_mode) begin
            case (size)
                EBSU_BYTE: lane_enable_n = ~(4'h1 << addr_lo);
                EBSU_HALF: lane_enable_n = addr_lo[1] ? 4'h3 : 4'hC;
                default:   lane_enable_n = 4'h0;
            endcase
        end else begin
            case (size)
                EBSU_BYTE: lane_enable_n = {addr_lo[1], 1'b1, ~addr_lo[0], addr_lo[0]};
                EBSU_HALF: lane_enable_n = {addr_lo[1], 1'b1, 2'b00};
                default:   lane_enable_n = {second_half, 1'b0, 2'b00};
            endcase
        end
    end
endmodule : ebsu_lanes
`default_nettype wire

// ---- verilog/ebsu_bridge.sv ----
`default_nettype none
// Notes on behaviour
// - In reset: status 0101, address, lanes, start, direction, grant high, data floats.
// - In hold: bus outputs float, grant low, chip selects driven high.
// - Chip-select pins stay high during hold, never floated.
// - External address is four shared pins plus 26 dedicated pins.
// - Select strap maps three 256 MB and one 32 MB image; else linear.
// - Memory region 40000000H-7FFFFFFFH is uncachable; other external memory cachable.
// - Built-in RAM hits finish in one clock, no external cycle, never cached.
// - No load/store to instruction RAM, no fetch from data RAM.
// - I/O C0000000H upward is internal, no external cycle, word only.
// - I/O never cached; in select mode it drives all four selects high.
// - Half strap inactive at reset gives a 32-bit bus, shared pins are lanes.
// - 32-bit lanes by address bits, all lanes for word and burst.
// - Half strap active: only D0-D15 used, D16-D31 float.
// - Half mode byte or halfword takes address then single data state.
// - Half mode upper halfword uses D0-D15 for both directions.
// - Half mode lower halfword uses D0-D15 for both directions.
// - Half mode word read samples low half then high half.
// - Half mode word write drives low half, then high half.
// - Cycle start marks every external cycle; direction shows read or write.
// - Half mode lanes per byte; flag high for byte/half, low for word/burst.
// - Half word uses bit 1 high in second half; burst alternates bit 1.
module ebsu_bridge
    import ebsu_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire ebsu_req_t   req,
    output logic             req_ready,
    output logic             rsp_valid,
    output ebsu_rsp_t        rsp,
    input  wire logic        half_width_strap,
    input  wire logic        upper_address_select,
    input  wire logic        clock_ratio_strap,
    output logic             clock_ratio,
    input  wire logic        ready_n,
    input  wire logic        bus_hold_request,
    output logic             bus_hold_grant,
    output logic [31:0]      addr_o,
    output logic [31:0]      addr_oe_n,
    output logic [3:0]       lane_enable_n,
    output logic             lanes_oe_n,
    output logic [3:0]       bus_status_code,
    output logic             status_oe_n,
    output logic             cycle_start_n,
    output logic             read_write,
    output logic             ctrl_oe_n,
    input  wire logic [31:0] data_i,
    output logic [31:0]      data_o,
    output logic [31:0]      data_oe_n
);
    // ********************************************************************
    // Pin synchronisers and strap capture.
    // ********************************************************************
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic       ready_s;
    logic       hold_s;
    logic       half_mode;
    logic       cs_mode;
    logic       ratio;
    logic       strap_taken;

    // The synchronisers keep running through reset, so the straps have settled
    // by the time reset is released and the capture below reads them.
    always_ff @(posedge sys_clk) begin
        sync1 <= {clock_ratio_strap, ~ready_n, bus_hold_request, half_width_strap, upper_address_select};
        sync2 <= sync1;
    end
    assign ready_s = sync2[3];
    assign hold_s  = sync2[2];

    // Straps are caught at the first edge after reset release, then frozen.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strap_taken <= 1'b0;
            half_mode   <= 1'b0;
            cs_mode     <= 1'b0;
            ratio       <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            half_mode   <= sync2[1];
            cs_mode     <= sync2[0];
            ratio       <= sync2[4];
        end
    end
    assign clock_ratio = ratio;

    // ********************************************************************
    // Address space decode.
    // ********************************************************************
    function automatic logic is_iram(input logic [31:0] a);
        return (a & IRAM_MASK) == IRAM_BASE;
    endfunction : is_iram

    function automatic logic is_dram(input logic [31:0] a);
        return (a & IRAM_MASK) == DRAM_BASE;
    endfunction : is_dram

    logic internal_hit;
    logic access_fault;
    logic mem_cachable;
    always_comb begin
        internal_hit = 1'b0;
        access_fault = 1'b0;
        mem_cachable = 1'b0;
        if (req.space == EBSU_IO) begin
            internal_hit = req.addr[31:30] == ADDR_TOP_IO_INT;
            access_fault = internal_hit && req.size != EBSU_WORD;
        end else begin
            internal_hit = is_iram(req.addr) || is_dram(req.addr);
            access_fault = (is_iram(req.addr) && req.space == EBSU_MEM_DATA)
                        || (is_dram(req.addr) && req.space == EBSU_MEM_FETCH);
            mem_cachable = !internal_hit && !(req.addr[31:28] >= ADDR_TOP_UNCACHED
                        && req.addr[31:28] <= ADDR_TOP_CS0_UNC);
        end
    end

    // Select mode: A28-A31 become one-hot-low selects over images.
    function automatic logic [3:0] region_select_n(input logic [31:0] a, input logic io);
        logic [3:0] sel;
        sel = 4'hF;
        if (io)
            sel = 4'hF;
        else if (a[31:25] == CS0_SMALL_TOP || a[31:28] == 4'hF)
            sel = 4'hE;
        else
            case (a[29:28])
                2'h0:    sel = 4'hD;
                2'h1:    sel = 4'hB;
                default: sel = 4'h7;
            endcase
        return sel;
    endfunction : region_select_n

    // ********************************************************************
    // Bus cycle sequencer.
    // ********************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SINGLE,
        ST_FIRST_HALF,
        ST_SECOND_HALF,
        ST_BURST,
        ST_HOLD
    } ebsu_state_t;

    ebsu_state_t state;
    ebsu_state_t next_state;
    ebsu_req_t   cur;
    ebsu_req_t   next_cur;
    logic [2:0]  beat;
    logic [2:0]  next_beat;
    logic [31:0] rbuf;
    logic [31:0] next_rbuf;
    logic        done;
    logic        next_done;
    ebsu_rsp_t   next_rsp;
    logic        hold_start;
    logic [3:0]  lanes;
    logic        second_half;

    assign req_ready = state == ST_IDLE && !hold_s && strap_taken;
    assign hold_start = hold_s && state == ST_IDLE;
    assign second_half = state == ST_SECOND_HALF || (state == ST_BURST && beat[0]);

    ebsu_lanes u_lanes (
        .half_mode     (half_mode),
        .size          (cur.size),
        .addr_lo       (cur.addr[1:0]),
        .second_half   (second_half),
        .lane_enable_n (lanes)
    );

    always_comb begin
        next_state = state;
        next_cur   = cur;
        next_beat  = beat;
        next_rbuf  = rbuf;
        next_done  = 1'b0;
        next_rsp   = rsp;
        case (state)
            ST_IDLE: begin
                if (hold_start) begin
                    next_state = ST_HOLD;
                end else if (req_valid && req_ready) begin
                    next_cur = req;
                    next_rsp.cachable = mem_cachable;
                    next_rsp.fault    = access_fault;
                    next_rsp.internal = internal_hit;
                    next_rsp.rdata    = 32'h0000_0000;
                    if (internal_hit || access_fault) begin
                        next_done = 1'b1;
                    end else begin
                        next_state = ST_ADDR;
                        next_beat  = 3'h0;
                    end
                end
            end
            ST_ADDR: begin
                if (cur.size == EBSU_BURST)
                    next_state = ST_BURST;
                else if (half_mode && cur.size == EBSU_WORD)
                    next_state = ST_FIRST_HALF;
                else
                    next_state = ST_SINGLE;
            end
            ST_SINGLE: begin
                if (ready_s) begin
                    next_rbuf  = half_mode ? (cur.addr[1] ? {data_i[15:0], 16'h0000}
                                : {16'h0000, data_i[15:0]}) : data_i;
                    next_done  = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_FIRST_HALF: begin
                if (ready_s) begin
                    next_rbuf[15:0] = data_i[15:0];
                    next_state      = ST_SECOND_HALF;
                end
            end
            ST_SECOND_HALF: begin
                if (ready_s) begin
                    next_rbuf[31:16] = data_i[15:0];
                    next_done        = 1'b1;
                    next_state       = ST_IDLE;
                end
            end
            ST_BURST: begin
                if (ready_s) begin
                    if (half_mode) begin
                        if (beat[0])
                            next_rbuf[31:16] = data_i[15:0];
                        else
                            next_rbuf[15:0] = data_i[15:0];
                    end else begin
                        next_rbuf = data_i;
                    end
                    next_beat = beat + 3'h1;
                    if (beat == 3'(half_mode ? BURST16_BEATS - 1 : BURST32_BEATS - 1)) begin
                        next_done  = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_HOLD: begin
                if (!hold_s)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        if (next_done && !(internal_hit && state == ST_IDLE))
            next_rsp.rdata = next_rbuf;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            cur       <= '0;
            beat      <= 3'h0;
            rbuf      <= 32'h0000_0000;
            rsp_valid <= 1'b0;
            rsp       <= '0;
        end else begin
            state     <= next_state;
            cur       <= next_cur;
            beat      <= next_beat;
            rbuf      <= next_rbuf;
            rsp_valid <= next_done;
            rsp       <= next_rsp;
        end
    end
    assign done = rsp_valid;

    // ********************************************************************
    // Pin drive.
    // ********************************************************************
    logic active;
    logic in_hold;
    assign active  = state != ST_IDLE && state != ST_HOLD;
    assign in_hold = state == ST_HOLD;

    always_comb begin
        addr_o          = {4'hF, cur.addr[DED_ADDR_HI:DED_ADDR_LO], 2'b00};
        addr_oe_n       = 32'h0000_0003;
        lane_enable_n   = active ? lanes : 4'hF;
        lanes_oe_n      = in_hold;
        bus_status_code = STATUS_IDLE;
        status_oe_n     = in_hold;
        cycle_start_n   = state != ST_ADDR;
        read_write      = active ? !cur.write : 1'b1;
        ctrl_oe_n       = in_hold;
        bus_hold_grant  = !in_hold;
        data_o          = 32'h0000_0000;
        data_oe_n       = 32'hFFFF_FFFF;
        if (active)
            bus_status_code = cur.space == EBSU_IO ? STATUS_IO
                            : cur.space == EBSU_MEM_FETCH ? STATUS_FETCH : STATUS_MEM;
        if (cs_mode) begin
            addr_o[31:28] = active ? region_select_n(cur.addr, cur.space == EBSU_IO) : 4'hF;
            addr_oe_n[31:28] = 4'h0;
        end else begin
            addr_o[31:28] = cur.addr[31:28];
        end
        if (in_hold)
            addr_oe_n[27:0] = 28'hFFF_FFFF;
        if (in_hold && !cs_mode)
            addr_oe_n[31:28] = 4'hF;
        if (active && cur.write) begin
            if (!half_mode) begin
                data_o    = cur.wdata;
                data_oe_n = 32'h0000_0000;
            end else begin
                data_oe_n = 32'hFFFF_0000;
                if (state == ST_SECOND_HALF || (cur.size == EBSU_HALF && cur.addr[1]))
                    data_o[15:0] = cur.wdata[31:16];
                else
                    data_o[15:0] = cur.wdata[15:0];
            end
        end
        if (rst) begin
            bus_status_code = STATUS_AT_RESET;
            addr_o          = 32'hFFFF_FFFC;
            addr_oe_n       = 32'h0000_0003;
            lane_enable_n   = 4'hF;
            lanes_oe_n      = 1'b0;
            status_oe_n     = 1'b0;
            cycle_start_n   = 1'b1;
            read_write      = 1'b1;
            ctrl_oe_n       = 1'b0;
            bus_hold_grant  = 1'b1;
            data_oe_n       = 32'hFFFF_FFFF;
        end
    end

    // ********************************************************************
    // Checks.
    // ********************************************************************
    a_hold_grant_low: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_HOLD |-> !bus_hold_grant && ctrl_oe_n && addr_oe_n[27:0] == 28'hFFF_FFFF)
        else $error("hold outputs wrong");
    a_cs_held_high: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_HOLD && cs_mode |-> addr_oe_n[31:28] == 4'h0 && addr_o[31:28] == 4'hF)
        else $error("selects not high in hold");
    a_internal_no_cycle: assert property (@(posedge sys_clk) disable iff (rst)
        req_valid && req_ready && internal_hit |=> rsp_valid && state == ST_IDLE)
        else $error("internal access used bus");
    a_start_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(cycle_start_n) |=> cycle_start_n && state != ST_IDLE)
        else $error("cycle start wrong");
    a_upper_data_float: assert property (@(posedge sys_clk) disable iff (rst)
        half_mode |-> data_oe_n[31:16] == 16'hFFFF)
        else $error("upper data driven in half mode");
    a_word_half_seq: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_ADDR && half_mode && cur.size == EBSU_WORD |=> state == ST_FIRST_HALF)
        else $error("half word sequence wrong");
    a_second_half_a1: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_SECOND_HALF |-> lane_enable_n == 4'h8)
        else $error("second half lanes wrong");
    a_wait_repeats: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_SINGLE && !ready_s |=> state == ST_SINGLE)
        else $error("wait state not held");
    a_word32_lanes: assert property (@(posedge sys_clk) disable iff (rst)
        !half_mode && state == ST_SINGLE && cur.size == EBSU_WORD |-> lane_enable_n == 4'h0)
        else $error("word lanes wrong");
    a_io_fault: assert property (@(posedge sys_clk) disable iff (rst)
        req_valid && req_ready && req.space == EBSU_IO && req.addr[31:30] == 2'h3
        && req.size != EBSU_WORD |=> rsp_valid && rsp.fault)
        else $error("io size fault missed");
    c_burst16: cover property (@(posedge sys_clk) disable iff (rst)
        half_mode && state == ST_BURST && beat == 3'h7 && ready_s);
    c_word16: cover property (@(posedge sys_clk) disable iff (rst) state == ST_SECOND_HALF && ready_s);
    c_hold: cover property (@(posedge sys_clk) disable iff (rst) state == ST_HOLD);
    c_internal: cover property (@(posedge sys_clk) disable iff (rst) done && rsp.internal);
endmodule : ebsu_bridge
`default_nettype wire

// ---- tb/ebsu_mem.sv ----
`default_nettype none
module ebsu_mem
    import ebsu_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  wait_cycles,
    input  wire logic        half,
    input  wire logic [31:0] addr_o,
    input  wire logic [3:0]  lane_enable_n,
    input  wire logic [3:0]  bus_status_code,
    input  wire logic        cycle_start_n,
    input  wire logic        read_write,
    input  wire logic [31:0] data_o,
    input  wire logic [31:0] data_oe_n,
    output logic             ready_n,
    output logic [31:0]      data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt;
    logic [31:0] word;
    logic [31:0] last;
    assign word = {addr_o[27:2], addr_o[7:2]};
    // Ready is held low from the end of the wait count until the bus goes idle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt     <= 4'h0;
            ready_n <= 1'b1;
            last    <= 32'h0000_0000;
        end else begin
            last <= data_i;
            if (!cycle_start_n) begin
                cnt     <= wait_cycles;
                ready_n <= 1'b1;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else begin
                ready_n <= (bus_status_code == STATUS_IDLE);
            end
        end
    end
    // Undriven lanes show the inverse of their last level.
    always_comb begin
        data_i = ~last;
        if (read_write && bus_status_code != STATUS_IDLE) begin
            if (half) begin
                data_i[15:0] = lane_enable_n[3] ? word[31:16] : word[15:0];
            end else begin
                data_i = word;
            end
        end
        data_i = (data_i & data_oe_n) | (data_o & ~data_oe_n);
    end
endmodule : ebsu_mem
`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none
module testbench;
    import ebsu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst, req_valid, req_ready, rsp_valid, half_width_strap, upper_address_select;
    logic        clock_ratio_strap, ready_n, bus_hold_request, bus_hold_grant, lanes_oe_n, status_oe_n;
    logic        cycle_start_n, read_write, ctrl_oe_n, rw_seen, wchk;
    logic [3:0]  lane_enable_n, bus_status_code, wait_cycles, lanes_seen;
    logic [31:0] addr_o, addr_oe_n, data_i, data_o, data_oe_n, wexp, a;
    ebsu_req_t   req;
    ebsu_rsp_t   rsp, r;
    int          fails, total_checks, starts, n, j;
    ebsu_size_t  szs[8] = '{EBSU_BYTE, EBSU_BYTE, EBSU_BYTE, EBSU_BYTE, EBSU_HALF, EBSU_HALF, EBSU_WORD, EBSU_BURST};
    logic [1:0]  los[8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [31:0] ia[6] = '{IRAM_BASE, DRAM_BASE, IRAM_BASE, DRAM_BASE, 32'hC000_0000, 32'hC000_0010};
    ebsu_space_t isp[6] = '{EBSU_MEM_FETCH, EBSU_MEM_DATA, EBSU_MEM_DATA, EBSU_MEM_FETCH, EBSU_IO, EBSU_IO};

    ebsu_bridge u_ebsu_bridge (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .half_width_strap(half_width_strap),
        .upper_address_select(upper_address_select), .clock_ratio_strap(clock_ratio_strap), .clock_ratio(),
        .ready_n(ready_n), .bus_hold_request(bus_hold_request), .bus_hold_grant(bus_hold_grant),
        .addr_o(addr_o), .addr_oe_n(addr_oe_n), .lane_enable_n(lane_enable_n), .lanes_oe_n(lanes_oe_n),
        .bus_status_code(bus_status_code), .status_oe_n(status_oe_n), .cycle_start_n(cycle_start_n),
        .read_write(read_write), .ctrl_oe_n(ctrl_oe_n), .data_i(data_i), .data_o(data_o), .data_oe_n(data_oe_n));
    ebsu_mem u_ebsu_mem (.sys_clk(sys_clk), .rst(rst), .wait_cycles(wait_cycles), .half(half_width_strap),
        .addr_o(addr_o), .lane_enable_n(lane_enable_n), .bus_status_code(bus_status_code),
        .cycle_start_n(cycle_start_n), .read_write(read_write), .data_o(data_o), .data_oe_n(data_oe_n),
        .ready_n(ready_n), .data_i(data_i));

    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (!ctrl_oe_n && !cycle_start_n) begin
            starts++;
            lanes_seen = lane_enable_n;
            rw_seen = read_write;
        end
        if (half_width_strap && !rst) begin
            chk(32'(data_oe_n[31:16]), 32'h0000_FFFF);
            if (wchk && !data_oe_n[0]) chk(32'(data_o[15:0]), 32'(lane_enable_n[3] ? wexp[31:16] : wexp[15:0]));
        end
    end

    function automatic logic [3:0] lanes(input logic hm, input ebsu_size_t sz, input logic [1:0] lo);
        if (sz == EBSU_BYTE) return hm ? {lo[1], 1'b1, ~(2'h1 << lo[0])} : ~(4'h1 << lo);
        if (sz == EBSU_HALF) return hm ? {lo[1], 3'h4} : (lo[1] ? 4'h3 : 4'hC);
        return 4'h0;
    endfunction : lanes

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic xfer(input logic w, input ebsu_size_t sz, input ebsu_space_t sp);
        int k;
        k = 0;
        n = starts;
        req_valid <= 1'b1;
        req <= '{a, w, sz, sp, wexp};
        do begin @(posedge sys_clk); k++; end while (!req_ready && k < 300);
        req_valid <= 1'b0;
        do begin @(posedge sys_clk); k++; end while (!rsp_valid && k < 300);
        r = rsp;
        if (k >= 300) begin
            fails++;
            $display("[FAIL] %0t no answer", $time);
            give_verdict();
        end
    endtask : xfer

    task automatic do_reset(input logic hm);
        rst <= 1'b1;
        half_width_strap <= hm;
        repeat (5) @(posedge sys_clk);
        chk(32'({bus_status_code, lane_enable_n, cycle_start_n, read_write, bus_hold_grant}), 32'({STATUS_AT_RESET, 7'h7F}));
        chk(data_oe_n, 32'hFFFF_FFFF);
        chk(32'(addr_o[27:2]), 32'h03FF_FFFF);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : do_reset

    initial begin
        sys_clk = 1'b0; rst = 1'b1; req_valid = 1'b0; req = '0; half_width_strap = 1'b0; wchk = 1'b0;
        upper_address_select = 1'b0; bus_hold_request = 1'b0; wait_cycles = 4'h0; wexp = 32'h0000_0000;
        clock_ratio_strap = 1'b0;
        fails = 0; total_checks = 0; starts = 0; a = 32'h0000_0000;
        void'($urandom(32'h04a6));
        for (int m = 0; m < 2; m++) begin
            do_reset(m[0]);
            for (int k = 0; k < 24; k++) begin
                j = k % 8;
                a = ($urandom & 32'h0FFF_FFFC) | 32'h1000_0000 | {30'h0, los[j]};
                wexp = $urandom;
                wait_cycles <= 4'($urandom_range(0, 3));
                wchk = m[0] && (k & 1) && (szs[j] == EBSU_HALF || szs[j] == EBSU_WORD);
                xfer(k[0], szs[j], EBSU_MEM_DATA);
                wchk = 1'b0;
                chk(starts - n, 32'h0000_0001);
                chk(32'(rw_seen), 32'(!k[0]));
                chk(32'(lanes_seen), 32'(lanes(m[0], szs[j], los[j])));
                chk(32'(r.cachable), 32'h1);
                if (!k[0] && szs[j] == EBSU_WORD) chk(r.rdata, {a[27:2], a[7:2]});
            end
            a = 32'h4000_0000 | ($urandom & 32'h3FFF_FFFC);
            xfer(1'b0, EBSU_WORD, EBSU_MEM_DATA);
            chk(32'(r.cachable), 32'h0);
            for (int k = 0; k < 6; k++) begin
                a = ia[k];
                xfer(1'b0, k == 5 ? EBSU_BYTE : EBSU_WORD, isp[k]);
                chk(starts - n, 32'h0000_0000);
                chk(32'({r.fault, r.cachable}), 32'({k == 2 || k == 3 || k == 5, 1'b0}));
            end
            $display("bus mode %0d done", m);
        end
        upper_address_select <= 1'b1;
        do_reset(1'b0);
        bus_hold_request <= 1'b1;
        j = 0;
        do begin @(posedge sys_clk); j++; end while (bus_hold_grant !== 1'b0 && j < 50);
        repeat (2) @(posedge sys_clk);
        chk(32'({status_oe_n, ctrl_oe_n, lanes_oe_n, bus_hold_grant}), 32'h0000_000E);
        chk({data_oe_n[5:0], addr_oe_n[27:2]}, 32'hFFFF_FFFF);
        chk(32'({addr_oe_n[31:28], addr_o[31:28]}), 32'h0000_000F);
        bus_hold_request <= 1'b0;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
